// file: rtl/commutation_pkg.sv
// shared constants and carrier types for the commutation sequencer
package commutation_pkg;
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned COARSE_DIV = 512;
  localparam int unsigned FINE_DIV = 8;
  localparam logic [8:0] COARSE_LAST = 9'h1FF;
  localparam logic [2:0] FINE_LAST = 3'h7;
  localparam logic [7:0] PHASE_MID = 8'h80;
  localparam int unsigned PHASES_PER_REV = 24;
  localparam logic [4:0] PHASE_LAST = 5'h17;
  localparam logic [2:0] STATES_PER_CYCLE = 3'h6;
  localparam int unsigned PUMP_HZ = 300000;
  localparam int unsigned PUMP_HALF_CYC = CLK_HZ / (2 * PUMP_HZ);
  localparam logic [9:0] PUMP_HALF_LAST = 10'(PUMP_HALF_CYC - 1);
  localparam int unsigned BRAKE_DELAY_CYC = 200000;
  localparam logic [23:0] PERIOD_MAX = 24'hFFFFFF;
  localparam logic [23:0] PERIOD_INIT = 24'h000400;

  typedef enum logic [2:0] {
    ST_AH_BL = 3'b000,
    ST_AH_CL = 3'b001,
    ST_BH_CL = 3'b011,
    ST_BH_AL = 3'b010,
    ST_CH_AL = 3'b110,
    ST_CH_BL = 3'b111
  } comm_state_t;

  typedef enum logic [1:0] {
    RB_RUN = 2'b00,
    RB_COAST = 2'b01,
    RB_BRAKE = 2'b11
  } run_brake_t;

  typedef struct packed {
    logic a_hi;
    logic b_hi;
    logic c_hi;
    logic a_lo;
    logic b_lo;
    logic c_lo;
  } bridge_t;

  typedef struct packed {
    logic charge_sw;
    logic transfer_sw;
  } pump_t;
endpackage

// file: rtl/sensorless_commutation_sequencer.sv
// six-step sensorless commutation sequencer with mask, brake and clock dividers
`timescale 1ns/1ps
`default_nettype none
module sensorless_commutation_sequencer
  import commutation_pkg::*;
#(
  parameter int unsigned BRAKE_DELAY = BRAKE_DELAY_CYC
) (
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // control
  input wire logic i_run,
  input wire logic i_bemf_cross,
  input wire logic i_seq_reset,
  input wire logic i_meas_start,
  // bridge and status
  output bridge_t o_bridge,
  output logic o_spin_toggle,
  output logic [4:0] o_phase_index,
  output logic [2:0] o_sense_phase,
  // phase counter rates and preset
  output logic o_coarse_tick,
  output logic o_fine_tick,
  output logic o_counter_preset,
  output logic [7:0] o_preset_value,
  // charge pump switches
  output pump_t o_pump
);

  function automatic bridge_t drive_of(input comm_state_t s);
    bridge_t b;
    b = '0;
    case (s)
      ST_AH_BL: begin b.a_hi = 1'b1; b.b_lo = 1'b1; end
      ST_AH_CL: begin b.a_hi = 1'b1; b.c_lo = 1'b1; end
      ST_BH_CL: begin b.b_hi = 1'b1; b.c_lo = 1'b1; end
      ST_BH_AL: begin b.b_hi = 1'b1; b.a_lo = 1'b1; end
      ST_CH_AL: begin b.c_hi = 1'b1; b.a_lo = 1'b1; end
      ST_CH_BL: begin b.c_hi = 1'b1; b.b_lo = 1'b1; end
      default: b = '0;
    endcase
    return b;
  endfunction

  function automatic logic [2:0] float_of(input comm_state_t s);
    case (s)
      ST_AH_BL, ST_BH_AL: float_of = 3'h1;
      ST_AH_CL, ST_CH_AL: float_of = 3'h2;
      default: float_of = 3'h4;
    endcase
  endfunction

  function automatic comm_state_t next_of(input comm_state_t s);
    case (s)
      ST_AH_BL: next_of = ST_AH_CL;
      ST_AH_CL: next_of = ST_BH_CL;
      ST_BH_CL: next_of = ST_BH_AL;
      ST_BH_AL: next_of = ST_CH_AL;
      ST_CH_AL: next_of = ST_CH_BL;
      default: next_of = ST_AH_BL;
    endcase
  endfunction

  // synchroniser and edge detect
  logic cross_meta_q, cross_sync_q, cross_prev_q;
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      cross_meta_q <= 1'b0;
      cross_sync_q <= 1'b0;
      cross_prev_q <= 1'b0;
    end else if (i_clk_en) begin
      cross_meta_q <= i_bemf_cross;
      cross_sync_q <= cross_meta_q;
      cross_prev_q <= cross_sync_q;
    end
  end
  wire cross_edge = cross_sync_q ^ cross_prev_q;

  // run/brake sequencing
  run_brake_t rb_q;
  logic [23:0] brake_cnt_q;
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      rb_q <= RB_COAST;
      brake_cnt_q <= '0;
    end else if (i_clk_en) begin
      case (rb_q)
        RB_RUN: begin
          if (!i_run) begin
            rb_q <= RB_COAST;
            brake_cnt_q <= '0;
          end
        end
        RB_COAST: begin
          if (i_run) begin
            rb_q <= RB_RUN;
          end else if (brake_cnt_q >= 24'(BRAKE_DELAY - 1)) begin
            rb_q <= RB_BRAKE;
          end else begin
            brake_cnt_q <= brake_cnt_q + 24'h000001;
          end
        end
        RB_BRAKE: begin
          if (i_run) begin
            rb_q <= RB_RUN;
          end
        end
        default: rb_q <= RB_COAST;
      endcase
    end
  end
  wire running = (rb_q == RB_RUN) && i_run;

  // commutation timing
  comm_state_t state_q;
  logic [4:0] phase_q;
  logic [23:0] period_cnt_q, last_period_q;
  logic [23:0] mask_cnt_q, delay_cnt_q;
  logic masked_q, delay_arm_q;
  wire commutate = running && delay_arm_q && (delay_cnt_q == '0);
  wire cross_ok = running && cross_edge && !masked_q && !delay_arm_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state_q <= ST_AH_BL;
      phase_q <= '0;
      period_cnt_q <= '0;
      last_period_q <= PERIOD_INIT;
      mask_cnt_q <= '0;
      delay_cnt_q <= '0;
      masked_q <= 1'b1;
      delay_arm_q <= 1'b0;
    end else if (i_clk_en) begin
      if (period_cnt_q != PERIOD_MAX) begin
        period_cnt_q <= period_cnt_q + 24'h000001;
      end
      if (i_seq_reset) begin
        state_q <= ST_AH_BL;
        phase_q <= '0;
        // restart period measurement so a stale count cannot stretch the mask
        period_cnt_q <= '0;
        masked_q <= 1'b0;
        delay_arm_q <= 1'b0;
      end else if (cross_ok) begin
        masked_q <= 1'b1;
        delay_arm_q <= 1'b1;
        // 30 deg is half of a 60 deg state period
        delay_cnt_q <= {1'b0, last_period_q[23:1]};
      end else if (commutate) begin
        state_q <= next_of(state_q);
        phase_q <= (phase_q == PHASE_LAST) ? 5'h00 : phase_q + 5'h01;
        last_period_q <= period_cnt_q;
        period_cnt_q <= '0;
        delay_arm_q <= 1'b0;
        mask_cnt_q <= {2'b00, period_cnt_q[23:2]};
      end else begin
        if (delay_arm_q) begin
          delay_cnt_q <= delay_cnt_q - 24'h000001;
        end else if (masked_q) begin
          if (mask_cnt_q == '0) begin
            masked_q <= 1'b0;
          end else begin
            mask_cnt_q <= mask_cnt_q - 24'h000001;
          end
        end
      end
    end
  end

  // motion indicator
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_spin_toggle <= 1'b0;
    end else if (i_clk_en && cross_ok) begin
      o_spin_toggle <= ~o_spin_toggle;
    end
  end

  // bridge drive
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_bridge <= '0;
      o_phase_index <= '0;
      o_sense_phase <= '0;
    end else if (i_clk_en) begin
      o_phase_index <= phase_q;
      o_sense_phase <= float_of(state_q);
      if (running) begin
        o_bridge <= drive_of(state_q);
      end else if (rb_q == RB_BRAKE) begin
        o_bridge <= '{a_lo: 1'b1, b_lo: 1'b1, c_lo: 1'b1, default: 1'b0};
      end else begin
        o_bridge <= '0;
      end
    end
  end

  // phase counter rate dividers
  logic [8:0] coarse_div_q;
  logic [2:0] fine_div_q;
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      coarse_div_q <= '0;
      fine_div_q <= '0;
      o_coarse_tick <= 1'b0;
      o_fine_tick <= 1'b0;
    end else if (i_clk_en) begin
      coarse_div_q <= coarse_div_q + 9'h001;
      fine_div_q <= fine_div_q + 3'h1;
      o_coarse_tick <= (coarse_div_q == COARSE_LAST);
      o_fine_tick <= (fine_div_q == FINE_LAST);
    end
  end

  // mid-scale preset request
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_counter_preset <= 1'b0;
      o_preset_value <= PHASE_MID;
    end else if (i_clk_en) begin
      o_counter_preset <= i_meas_start;
      o_preset_value <= PHASE_MID;
    end
  end

  // charge pump oscillator
  logic [9:0] pump_cnt_q;
  logic pump_half_q;
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      pump_cnt_q <= '0;
      pump_half_q <= 1'b0;
      o_pump <= '0;
    end else if (i_clk_en) begin
      if (pump_cnt_q == PUMP_HALF_LAST) begin
        pump_cnt_q <= '0;
        pump_half_q <= ~pump_half_q;
      end else begin
        pump_cnt_q <= pump_cnt_q + 10'h001;
      end
      o_pump.charge_sw <= ~pump_half_q;
      o_pump.transfer_sw <= pump_half_q;
    end
  end

endmodule
`default_nettype wire

// file: sim/commutation_asserts.sv
// port assertions for the commutation sequencer
`timescale 1ns/1ps
`default_nettype none
module commutation_asserts
  import commutation_pkg::*;
#(
  parameter int unsigned BRAKE_DELAY = 20
) (
  // clock, reset, inputs
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_run,
  input wire logic i_bemf_cross,
  input wire logic i_seq_reset,
  input wire logic i_meas_start,
  // outputs
  input wire bridge_t o_bridge,
  input wire logic o_spin_toggle,
  input wire logic [4:0] o_phase_index,
  input wire logic [2:0] o_sense_phase,
  input wire logic o_coarse_tick,
  input wire logic o_fine_tick,
  input wire logic o_counter_preset,
  input wire logic [7:0] o_preset_value,
  input wire pump_t o_pump
);
  localparam int BD_LO = BRAKE_DELAY;
  localparam int BD_HI = BRAKE_DELAY + 4;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // cycles since last coarse tick, parked at all ones until the first
  logic [9:0] gap_q;
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || o_coarse_tick) begin
      gap_q <= (!i_resetn) ? 10'h3FF : 10'h000;
    end else if (gap_q != 10'h3FF) begin
      gap_q <= gap_q + 10'h001;
    end
  end
  sequence seq_held;
    (i_seq_reset && i_run)[*4];
  endsequence
  sequence coast_run;
    ##1 (o_bridge == 6'h00)[*8];
  endsequence
  a_coarse_gap: assert property (o_coarse_tick && gap_q != 10'h3FF |-> gap_q == 10'h1FF)
    else $error("coarse tick spacing off");
  a_fine_gap: assert property (o_fine_tick |=> !o_fine_tick[*7] ##1 o_fine_tick)
    else $error("fine tick spacing off");
  a_index_step: assert property ($changed(o_phase_index) && !$past(i_seq_reset) && !i_seq_reset |->
    o_phase_index == (($past(o_phase_index) == PHASE_LAST) ? 5'h00 : $past(o_phase_index) + 5'h01))
    else $error("phase index step wrong");
  a_state_one: assert property (seq_held |-> o_bridge == 6'b100010 && o_sense_phase == 3'b001)
    else $error("first state drive wrong");
  a_state_two: assert property (o_bridge == 6'b100001 |-> o_sense_phase == 3'b010)
    else $error("second state sense wrong");
  a_spin_cause: assert property ($changed(o_spin_toggle) |->
    $past(i_bemf_cross, 3) != $past(i_bemf_cross, 4) || $past(i_bemf_cross, 4) != $past(i_bemf_cross, 5))
    else $error("spin toggle without crossing");
  a_coast_off: assert property ($fell(i_run) |=> coast_run)
    else $error("bridge not off on coast");
  a_brake_lows: assert property ($fell(i_run) |-> ##[BD_LO:BD_HI] o_bridge == 6'b000111)
    else $error("low side brake missing");
  a_pump_order: assert property ($rose(o_pump.transfer_sw) |-> !o_pump.charge_sw && $past(o_pump.charge_sw))
    else $error("pump switch order wrong");
  a_preset_mid: assert property (i_meas_start |=> o_counter_preset && o_preset_value == 8'h80)
    else $error("preset missing");
endmodule
bind sensorless_commutation_sequencer commutation_asserts #(.BRAKE_DELAY(BRAKE_DELAY)) u_chk (.*);
`default_nettype wire

// file: sim/bemf_motor_model.sv
// motor stand-in answering each commutation with one back-emf crossing
`timescale 1ns/1ps
`default_nettype none
module bemf_motor_model
  import commutation_pkg::*;
#(
  parameter int DLY = 300
) (
  // clock and gate drive
  input wire logic i_clk_sys,
  input wire bridge_t i_bridge,
  // comparator level
  output logic o_cross
);
  bridge_t last_q = '0;
  int cnt_q = 0;
  logic cross_q = 1'b0;
  assign o_cross = cross_q;
  always @(posedge i_clk_sys) begin
    last_q <= i_bridge;
    if (i_bridge != last_q) begin
      cnt_q <= 0;
    end else if (cnt_q < DLY) begin
      cnt_q <= cnt_q + 1;
    end
    // floating winding crosses a fixed time into each state
    if (cnt_q == DLY - 1 && i_bridge != '0) begin
      cross_q <= ~cross_q;
    end
  end
endmodule
`default_nettype wire

// file: sim/sensorless_commutation_sequencer_bench.sv
// self-checking bench for the commutation sequencer
`timescale 1ns/1ps
`default_nettype none
module sensorless_commutation_sequencer_bench;
  import commutation_pkg::*;
  logic i_clk_sys = 0, i_resetn = 0, i_clk_en = 1, i_run = 0;
  logic i_seq_reset = 0, i_meas_start = 0, i_bemf_cross;
  bridge_t o_bridge;
  logic o_spin_toggle, o_coarse_tick, o_fine_tick, o_counter_preset;
  logic [4:0] o_phase_index;
  logic [2:0] o_sense_phase;
  logic [7:0] o_preset_value;
  pump_t o_pump;
  int num_errors = 0, compares = 0;
  initial forever #2.5 i_clk_sys = ~i_clk_sys;
  sensorless_commutation_sequencer #(.BRAKE_DELAY(20)) u_dut (.*);
  bemf_motor_model #(.DLY(300)) u_motor (.i_clk_sys(i_clk_sys), .i_bridge(o_bridge), .o_cross(i_bemf_cross));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  // counts phase steps until the index reads v, bounded
  task automatic wait_idx(input logic [4:0] v, output int steps);
    logic [4:0] prev;
    steps = 0;
    prev = o_phase_index;
    for (int n = 0; n < 30000 && o_phase_index !== v; n++) begin
      cyc(1);
      steps += (o_phase_index !== prev);
      prev = o_phase_index;
    end
  endtask
  task automatic t_reset;
    chk(8'(o_bridge), 8'h00, "bridge in reset");
    chk(8'(o_spin_toggle), 8'h00, "spin in reset");
    chk(o_preset_value, 8'h80, "preset value");
    $display("reset test done");
  endtask
  task automatic t_ticks;
    int f, c;
    f = 0;
    c = 0;
    repeat (1024) begin
      cyc(1);
      f += o_fine_tick;
      c += o_coarse_tick;
    end
    chk(8'(f), 8'h80, "fine rate");
    chk(8'(c), 8'h02, "coarse rate");
    $display("tick test done");
  endtask
  task automatic t_preset;
    i_meas_start = 1;
    cyc(1);
    i_meas_start = 0;
    chk(8'(o_counter_preset), 8'h01, "preset echo");
    cyc(1);
    chk(8'(o_counter_preset), 8'h00, "preset drop");
    $display("preset test done");
  endtask
  task automatic t_run;
    int steps;
    i_run = 1;
    i_seq_reset = 1;
    cyc(4);
    chk(8'(o_bridge), 8'h22, "first state");
    chk(8'(o_sense_phase), 8'h01, "sense c");
    chk(8'(o_phase_index), 8'h00, "index start");
    i_seq_reset = 0;
    wait_idx(5'h01, steps);
    cyc(2);
    chk(8'(o_bridge), 8'h21, "second state");
    chk(8'(o_sense_phase), 8'h02, "sense b");
    chk(8'(o_spin_toggle), 8'h01, "first toggle");
    wait_idx(5'h00, steps);
    chk(8'(steps), 8'h17, "steps per turn");
    $display("run test done");
  endtask
  task automatic t_brake;
    i_run = 0;
    cyc(3);
    chk(8'(o_bridge), 8'h00, "coast");
    cyc(25);
    chk(8'(o_bridge), 8'h07, "brake");
    $display("brake test done");
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    cyc(10);
    t_reset;
    cyc(10);
    i_resetn = 1;
    t_ticks;
    t_preset;
    t_run;
    t_brake;
    results;
  end
  initial begin
    #400000;
    num_errors++;
    results;
  end
endmodule
`default_nettype wire
